/* shared/cursor_font_consts.vh */
// command codes, field positions and reset values for the
// cursor auto-move and font-map select command decoder.
// assumes inclusion by bare name from the design files.
`ifndef CURSOR_FONT_CONSTS_VH
`define CURSOR_FONT_CONSTS_VH

// command byte codes
`define CMD_CURSOR_AUTO_MOVE 8'h60
`define CMD_FONT_MAP_SELECT 8'h70

// operand field positions within the first operand byte
`define AUTO_MOVE_BIT 0
`define FONT_SEL_MSB 1
`define FONT_SEL_LSB 0

// font selection field encodings
`define FONT_SEL_DEFAULT_A 2'h0
`define FONT_SEL_DEFAULT_B 2'h1
`define FONT_SEL_ALT_ONE 2'h2
`define FONT_SEL_ALT_TWO 2'h3

// widths
`define BYTE_W 8
`define CURSOR_PTR_W 16

// reset values
`define AUTO_MOVE_RESET 1'b0
`define FONT_SEL_RESET 2'h0
`define CURSOR_PTR_RESET 16'h0000
`define OPERAND_RESET 8'h00

`endif

/* design/cursor_pointer_unit.v */
// cursor pointer register: loaded by the cursor set command, stepped by
// one up or down when the decoder asks for an auto-move step.
// assumes load and step are one-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
`include "cursor_font_consts.vh"

module cursor_pointer_unit (
  input wire clk,
  input wire rstn,
  input wire load,
  input wire [`CURSOR_PTR_W-1:0] load_value,
  input wire step,
  input wire step_down,
  output wire [`CURSOR_PTR_W-1:0] ptr
);

  reg [`CURSOR_PTR_W-1:0] ptr_q;
  reg [`CURSOR_PTR_W-1:0] ptr_d;

  // a load in the same cycle as a step wins: software's position is final
  always @*
  begin
    ptr_d = ptr_q;
    if (load)
    begin
      ptr_d = load_value; // [R07]
    end
    else if (step)
    begin
      if (step_down)
      begin
        ptr_d = ptr_q - {{(`CURSOR_PTR_W-1){1'b0}}, 1'b1}; // [R04]
      end
      else
      begin
        ptr_d = ptr_q + {{(`CURSOR_PTR_W-1){1'b0}}, 1'b1}; // [R04]
      end
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ptr_q <= `CURSOR_PTR_RESET;
    end
    else
    begin
      ptr_q <= ptr_d;
    end
  end

  assign ptr = ptr_q;

endmodule // cursor_pointer_unit

`default_nettype wire

/* design/cursor_automove_font_select_cmds.v */
// command decoder for the cursor auto-move and font-map select commands,
// with the cursor pointer that auto-move steps.
// assumes the host port has already been reduced to one-cycle write
// strobes on clk: one for operand bytes, one for command bytes.
//
// How it works
// R01 - command 60h sets auto-move from first operand
// R02 - host sends two operands; second one ignored
// R03 - operand bit 0 switches auto-move; rest ignored
// R04 - auto-move steps pointer after each data access
// R05 - command 70h takes font from operand bits 1:0
// R06 - 00/01 default font, 10 alt one, 11 two
// R07 - stepped pointer is the cursor-set pointer
// R08 - reset: auto-move off, default font selected
`timescale 1ns/10ps
`default_nettype none
`include "cursor_font_consts.vh"

module cursor_automove_font_select_cmds (
  input wire clk,
  input wire rstn,
  // host operand and command byte writes
  input wire [`BYTE_W-1:0] host_byte,
  input wire operand_wr,
  input wire command_wr,
  // display data access done by the rest of the controller
  input wire data_access,
  input wire data_step_down,
  // cursor pointer set command from the rest of the decoder
  input wire cursor_set,
  input wire [`CURSOR_PTR_W-1:0] cursor_set_value,
  // results
  output wire [`CURSOR_PTR_W-1:0] cursor_ptr,
  output reg auto_move_en,
  output reg [1:0] font_sel,
  output reg alt_font_map_one,
  output reg alt_font_map_two,
  output wire [1:0] operand_count,
  output reg cmd_done,
  output reg cmd_short
);

  // operand collection states
  localparam [1:0] ST_EMPTY = 2'h0;
  localparam [1:0] ST_ONE = 2'h1;
  localparam [1:0] ST_TWO = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`BYTE_W-1:0] first_operand_byte_q;
  reg [`BYTE_W-1:0] first_operand_byte_d;
  reg [`BYTE_W-1:0] second_operand_byte_q;
  reg [`BYTE_W-1:0] second_operand_byte_d;
  reg auto_move_q;
  reg auto_move_d;
  reg [1:0] font_sel_q;
  reg [1:0] font_sel_d;
  reg done_d;
  reg short_d;
  wire is_auto_move_cmd;
  wire is_font_cmd;
  wire ours;
  wire step;

  function cmd_match;
    input [`BYTE_W-1:0] code;
    input [`BYTE_W-1:0] code_ref;
    begin
      cmd_match = (code == code_ref);
    end
  endfunction

  assign is_auto_move_cmd = cmd_match(host_byte, `CMD_CURSOR_AUTO_MOVE);
  assign is_font_cmd = cmd_match(host_byte, `CMD_FONT_MAP_SELECT);
  assign ours = is_auto_move_cmd | is_font_cmd;

  // operand collection and command execution
  always @*
  begin
    state_d = state_q;
    first_operand_byte_d = first_operand_byte_q;
    second_operand_byte_d = second_operand_byte_q;
    auto_move_d = auto_move_q;
    font_sel_d = font_sel_q;
    done_d = 1'b0;
    short_d = 1'b0;
    if (command_wr)
    begin
      // any command byte consumes the collected operands
      state_d = ST_EMPTY;
      if (ours && state_q == ST_TWO)
      begin
        done_d = 1'b1;
        // second operand is held only for completeness, never decoded
        if (is_auto_move_cmd)
        begin
          auto_move_d = first_operand_byte_q[`AUTO_MOVE_BIT]; // [R01] [R03]
        end
        else
        begin
          font_sel_d =
            first_operand_byte_q[`FONT_SEL_MSB:`FONT_SEL_LSB]; // [R05]
        end
      end
      else if (ours)
      begin
        // fewer than two operands: command dropped, settings kept
        short_d = 1'b1; // [R02]
      end
    end
    else if (operand_wr)
    begin
      case (state_q)
        ST_EMPTY:
        begin
          first_operand_byte_d = host_byte;
          state_d = ST_ONE;
        end
        ST_ONE:
        begin
          second_operand_byte_d = host_byte; // [R02]
          state_d = ST_TWO;
        end
        ST_TWO:
        begin
          // a third byte begins a fresh operand pair
          first_operand_byte_d = host_byte;
          state_d = ST_ONE;
        end
        default:
        begin
          state_d = ST_EMPTY;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_EMPTY;
      first_operand_byte_q <= `OPERAND_RESET;
      second_operand_byte_q <= `OPERAND_RESET;
      auto_move_q <= `AUTO_MOVE_RESET; // [R08]
      font_sel_q <= `FONT_SEL_RESET; // [R08]
      cmd_done <= 1'b0;
      cmd_short <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      first_operand_byte_q <= first_operand_byte_d;
      second_operand_byte_q <= second_operand_byte_d;
      auto_move_q <= auto_move_d;
      font_sel_q <= font_sel_d;
      cmd_done <= done_d;
      cmd_short <= short_d;
    end
  end

  // auto-move and font map outputs, registered
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      auto_move_en <= `AUTO_MOVE_RESET;
      font_sel <= `FONT_SEL_RESET;
      alt_font_map_one <= 1'b0;
      alt_font_map_two <= 1'b0;
    end
    else
    begin
      auto_move_en <= auto_move_d;
      font_sel <= font_sel_d;
      alt_font_map_one <= (font_sel_d == `FONT_SEL_ALT_ONE); // [R06]
      alt_font_map_two <= (font_sel_d == `FONT_SEL_ALT_TWO); // [R06]
    end
  end

  // the step uses the setting in force when the access completes
  assign step = data_access & auto_move_q; // [R04]

  cursor_pointer_unit u_cursor (
    .clk(clk),
    .rstn(rstn),
    .load(cursor_set),
    .load_value(cursor_set_value),
    .step(step),
    .step_down(data_step_down),
    .ptr(cursor_ptr)
  ); // [R07]

  assign operand_count = state_q;

endmodule // cursor_automove_font_select_cmds

`default_nettype wire

/* tb/cmds_checker_sva.sv */
// checker for the auto-move and font-map command decoder
// assumes binding onto the decoder top, single clock domain
`timescale 1ns/10ps
`default_nettype none
module cmds_checker (
  input wire clk,
  input wire rstn,
  input wire [7:0] host_byte,
  input wire operand_wr,
  input wire command_wr,
  input wire data_access,
  input wire data_step_down,
  input wire cursor_set,
  input wire [15:0] cursor_set_value,
  input wire [15:0] cursor_ptr,
  input wire auto_move_en,
  input wire [1:0] font_sel,
  input wire alt_font_map_one,
  input wire alt_font_map_two,
  input wire [1:0] operand_count,
  input wire cmd_done,
  input wire cmd_short
);
  reg [1:0] op1_q;
  wire step = data_access && auto_move_en && !cursor_set;
  wire known = host_byte == 8'h60 || host_byte == 8'h70;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow of the first operand; a third operand restarts collection
  always @(posedge clk or negedge rstn)
    if (!rstn)
      op1_q <= 2'h0;
    else if (operand_wr && !command_wr && operand_count != 2'h1)
      op1_q <= host_byte[1:0];
  sequence s_cmd(c);
    command_wr && host_byte == c && operand_count == 2'h2;
  endsequence
  a_auto_set: assert property (
    s_cmd(8'h60) |=> cmd_done && auto_move_en == op1_q[0])
    else $error("auto set");
  a_font_set: assert property (
    s_cmd(8'h70) |=> cmd_done && font_sel == op1_q)
    else $error("font set");
  a_alt_map: assert property (
    alt_font_map_one == (font_sel == 2'h2) && alt_font_map_two == &font_sel)
    else $error("alt map");
  a_step_up: assert property (
    step && !data_step_down |=> cursor_ptr == $past(cursor_ptr) + 16'h0001)
    else $error("step up");
  a_step_down: assert property (
    step && data_step_down |=> cursor_ptr == $past(cursor_ptr) - 16'h0001)
    else $error("step down");
  a_ptr_load: assert property (
    cursor_set |=> cursor_ptr == $past(cursor_set_value))
    else $error("ptr load");
  a_ptr_hold: assert property (
    !cursor_set && !step |=> $stable(cursor_ptr))
    else $error("ptr hold");
  a_short_drop: assert property (
    command_wr && known && operand_count < 2'h2
    |=> cmd_short && !cmd_done && $stable(auto_move_en) && $stable(font_sel))
    else $error("short drop");
  a_reset_clear: assert property (
    $rose(rstn) |-> !auto_move_en && font_sel == 2'h0)
    else $error("reset clear");
endmodule // cmds_checker
bind cursor_automove_font_select_cmds cmds_checker u_chk (.clk, .rstn,
  .host_byte, .operand_wr, .command_wr, .data_access, .data_step_down,
  .cursor_set, .cursor_set_value, .cursor_ptr, .auto_move_en, .font_sel,
  .alt_font_map_one, .alt_font_map_two, .operand_count, .cmd_done,
  .cmd_short);
`default_nettype wire

/* tb/host_model.sv */
// host model: writes operand bytes, then the command byte
// assumes clk is the decoder clock; strobes move after rising edges
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [7:0] host_byte,
  output logic operand_wr,
  output logic command_wr
);
  initial
  begin
    host_byte = 8'h00;
    operand_wr = 1'b0;
    command_wr = 1'b0;
  end
  // fewer than two operands only when a refusal is wanted
  task send(input logic [7:0] op, input logic [7:0] code, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      host_byte <= (i == 0) ? op : ~op;
      operand_wr <= 1'b1;
    end
    @(posedge clk);
    operand_wr <= 1'b0;
    host_byte <= code;
    command_wr <= 1'b1;
    @(posedge clk);
    command_wr <= 1'b0;
    host_byte <= ~code;
  endtask
endmodule // host_model
`default_nettype wire

/* tb/test_cursor_automove_font_select_cmds.sv */
// bench for the auto-move and font-map command decoder
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); n_mismatch++; end end
module test_cursor_automove_font_select_cmds;
  logic clk, rstn, data_access, data_step_down, cursor_set;
  logic operand_wr, command_wr, auto_move_en, cmd_done, cmd_short;
  logic alt_font_map_one, alt_font_map_two;
  logic [15:0] cursor_set_value, cursor_ptr;
  logic [7:0] host_byte;
  logic [1:0] font_sel, operand_count, s;
  int n_mismatch = 0;
  int samples_checked = 0;
  host_model u_host (.clk, .host_byte, .operand_wr, .command_wr);
  cursor_automove_font_select_cmds u_dut (.clk, .rstn, .host_byte,
    .operand_wr, .command_wr, .data_access, .data_step_down, .cursor_set,
    .cursor_set_value, .cursor_ptr, .auto_move_en, .font_sel,
    .alt_font_map_one, .alt_font_map_two, .operand_count, .cmd_done,
    .cmd_short);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task auto_move;
    u_host.send(8'hFE, 8'h60, 2);
    #1 `CHK("auto", 1'b0, auto_move_en)
    u_host.send(8'h01, 8'h60, 2);
    #1 `CHK("done", 1'b1, cmd_done)
    `CHK("auto", 1'b1, auto_move_en)
    cursor_set <= 1'b1;
    @(posedge clk);
    cursor_set <= 1'b0;
    data_access <= 1'b1;
    #1 `CHK("load", 16'hFFFF, cursor_ptr)
    @(posedge clk);
    data_step_down <= 1'b1;
    #1 `CHK("up", 16'h0000, cursor_ptr)
    @(posedge clk);
    data_access <= 1'b0;
    #1 `CHK("down", 16'hFFFF, cursor_ptr)
    u_host.send(8'h00, 8'h60, 1);
    #1 `CHK("short", 1'b1, cmd_short)
    `CHK("auto", 1'b1, auto_move_en)
    `CHK("count", 2'h0, operand_count)
  endtask
  task font_sweep;
    for (int i = 0; i < 4; i++)
    begin
      s = i[1:0];
      u_host.send({6'h3F, s}, 8'h70, 2);
      #1 `CHK("font", s, font_sel)
      `CHK("one", s == 2'h2, alt_font_map_one)
      `CHK("two", s == 2'h3, alt_font_map_two)
    end
  endtask
  initial
  begin
    {rstn, data_access, data_step_down, cursor_set} = 4'h0;
    cursor_set_value = 16'hFFFF;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 `CHK("reset", 3'h0, {auto_move_en, font_sel})
    auto_move;
    font_sweep;
    complete_run;
  end
  // whole sequence is well under 100 cycles
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule // test_cursor_automove_font_select_cmds
`default_nettype wire
